// >>> rtl/charger_supervisor_fsm.sv
// supervisory state logic of a stand-alone battery charger
`timescale 1ns/100ps
`default_nettype none
// Function
// - new charge cycle starts only with temperature between cold and hot start thresholds.
// - temperature out of window suspends charging until back inside the start window.
// - temperature suspend acts by switching off both converter switches.
// - fault above recharge clears when battery falls below recharge, then detection.
// - charge-enable low or power-on reset clears any timer fault.
// - fault below recharge enables fault probe current while battery stays below.
// - rising above recharge with probe on drops probe, follows above-threshold path.
// - power-good asserted when no undervoltage, overvoltage or sleep; else released.
// - charging permitted only with charge-enable high and other conditions met.
// - charge-enable falling edge resets all timers and clears all faults.
// - floating charge-enable counts as low, so charging stays off.
// - indicators: charging on/off, complete off/on, everything else off/off.
// - after power-up detection starts by enabling the discharge sink.
// - low-battery within discharge window: sink off, charge at probe current.
// - recharge crossed within probe window: battery absent, restart detection.
// - either window expiring first means battery present, start a charge cycle.
// - input overvoltage disables charging and moves system supply to battery.
module charger_supervisor_fsm #(
    parameter longint DISCH_LEN = chg_sup_pkg::DISCH_CYCLES, // discharge window cycles
    parameter longint PROBE_LEN = chg_sup_pkg::PROBE_CYCLES // probe window cycles
) (
    input wire logic core_clk, // 10 MHz clock
    input wire logic rst, // async reset, high
    input wire logic clk_en, // freezes all state when low
    input wire logic charge_enable, // charge-enable pin level
    input wire logic temp_above_cold, // temperature warmer than cold threshold
    input wire logic temp_below_hot_start, // cooler than hot start threshold
    input wire logic temp_below_hot_cutoff, // cooler than hot cutoff threshold
    input wire logic bat_below_low, // battery under low_battery_level
    input wire logic bat_above_recharge, // battery above recharge threshold
    input wire logic undervoltage_lockout, // supply in lockout
    input wire logic input_overvoltage, // adapter above overvoltage threshold
    input wire logic sleep_mode, // device in sleep
    input wire logic safety_timeout, // safety timer expired, pulse
    input wire logic charge_done, // termination reached, pulse
    output logic converter_on, // both switches allowed to run
    output logic probe_charge, // charge at reduced probe current
    output logic discharge_sink, // discharge sink on sense_neg_node
    output logic fault_probe, // small fault probe current on
    output logic supply_from_battery, // system supply switched to battery
    output logic supply_good_out, // power-good open-drain output
    output logic supply_good_oe, // power-good driver enable
    output logic charge_indicator_a, // first indicator output
    output logic charge_indicator_a_oe, // first indicator enable
    output logic charge_indicator_b, // second indicator output
    output logic charge_indicator_b_oe, // second indicator enable
    output logic timer_fault // timer fault standing
);
    localparam logic [chg_sup_pkg::WIN_W-1:0] DISCH_N = DISCH_LEN[chg_sup_pkg::WIN_W-1:0];
    localparam logic [chg_sup_pkg::WIN_W-1:0] PROBE_N = PROBE_LEN[chg_sup_pkg::WIN_W-1:0];

    // ------------------------------------------------------------
    // condition decoding
    // ------------------------------------------------------------
    chg_sup_pkg::sup_state_t state, next_state;
    logic ce_prev;
    logic ce_fall;
    logic supply_ok;
    logic temp_start_ok;
    logic temp_run_ok;
    logic charge_allowed;
    logic win_load;
    logic win_expired;
    logic [chg_sup_pkg::WIN_W-1:0] win_len;

    assign ce_fall = ce_prev & ~charge_enable;
    // supply valid only outside lockout, overvoltage and sleep
    assign supply_ok = ~undervoltage_lockout & ~input_overvoltage & ~sleep_mode;
    // start window is cold to hot start
    assign temp_start_ok = temp_above_cold & temp_below_hot_start;
    // hot cutoff widens the running window
    assign temp_run_ok = temp_above_cold & temp_below_hot_cutoff;
    // charge-enable must be high; a floating pin is pulled down, so stays off
    assign charge_allowed = charge_enable & supply_ok;

    // ------------------------------------------------------------
    // detection window timer
    // ------------------------------------------------------------
    // windows timed from the internal counter
    assign win_load = (state != next_state) | ce_fall;
    assign win_len = (next_state == chg_sup_pkg::ST_PROBE) ? PROBE_N : DISCH_N;

    win_timer #(.W(chg_sup_pkg::WIN_W)) u_win (
        .core_clk(core_clk),
        .rst(rst),
        .ce(clk_en),
        .load(win_load),
        .length(win_len),
        .run(1'b1),
        .expired(win_expired)
    );

    // ------------------------------------------------------------
    // supervisor state machine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            chg_sup_pkg::ST_IDLE: begin
                // detection begins once powered and enabled
                if (charge_allowed) begin
                    next_state = chg_sup_pkg::ST_DISCH;
                end
            end
            chg_sup_pkg::ST_DISCH: begin
                // low level reached inside the window
                if (bat_below_low) begin
                    next_state = chg_sup_pkg::ST_PROBE;
                end else if (win_expired) begin
                    next_state = chg_sup_pkg::ST_CHARGE;
                end
            end
            chg_sup_pkg::ST_PROBE: begin
                if (bat_above_recharge) begin
                    next_state = chg_sup_pkg::ST_DISCH;
                end else if (win_expired) begin
                    next_state = chg_sup_pkg::ST_CHARGE;
                end
            end
            chg_sup_pkg::ST_CHARGE: begin
                if (safety_timeout) begin
                    next_state = bat_above_recharge ? chg_sup_pkg::ST_FAULT_HI
                                                    : chg_sup_pkg::ST_FAULT_LO;
                end else if (charge_done) begin
                    next_state = chg_sup_pkg::ST_DONE;
                end
            end
            chg_sup_pkg::ST_DONE: begin
                // battery sagged: back through detection
                if (!bat_above_recharge) begin
                    next_state = chg_sup_pkg::ST_DISCH;
                end
            end
            chg_sup_pkg::ST_FAULT_HI: begin
                // clears when battery falls under recharge
                if (!bat_above_recharge) begin
                    next_state = chg_sup_pkg::ST_DISCH;
                end
            end
            chg_sup_pkg::ST_FAULT_LO: begin
                // battery rose: drop probe, take above-threshold path
                if (bat_above_recharge) begin
                    next_state = chg_sup_pkg::ST_FAULT_HI;
                end
            end
            default: next_state = chg_sup_pkg::ST_IDLE;
        endcase
        // enable low clears faults and returns to idle
        if (!charge_allowed || ce_fall) begin
            next_state = chg_sup_pkg::ST_IDLE;
        end
    end

    // state and edge register, frozen by the clock enable
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= chg_sup_pkg::ST_IDLE;
            ce_prev <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            ce_prev <= charge_enable;
        end
    end

    // ------------------------------------------------------------
    // outputs, registered; supply outputs from the inputs, the others from the next state
    // ------------------------------------------------------------
    logic charging_n;
    logic temp_ok_n;
    logic suspended;
    logic temp_hold;
    // temperature gating; a running cycle uses the wider window, but after
    // a suspend it must come back inside the start window to resume
    assign temp_ok_n = (state == chg_sup_pkg::ST_CHARGE && !temp_hold) ? temp_run_ok
                                                                       : temp_start_ok;
    assign charging_n = (next_state == chg_sup_pkg::ST_CHARGE) ||
                        (next_state == chg_sup_pkg::ST_PROBE);
    // outside the window charging waits in place
    assign suspended = charging_n & ~temp_ok_n;

    // remembers a suspend, so the cutoff window alone cannot restart
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            temp_hold <= 1'b0;
        end else if (clk_en) begin
            temp_hold <= suspended;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            converter_on <= 1'b0;
            probe_charge <= 1'b0;
            discharge_sink <= 1'b0;
            fault_probe <= 1'b0;
            supply_from_battery <= 1'b0;
            supply_good_out <= chg_sup_pkg::IND_RESET;
            charge_indicator_a <= chg_sup_pkg::IND_RESET;
            charge_indicator_b <= chg_sup_pkg::IND_RESET;
            timer_fault <= 1'b0;
        end else if (clk_en) begin
            // both switches off whenever suspended or not allowed
            converter_on <= charging_n & ~suspended;
            probe_charge <= (next_state == chg_sup_pkg::ST_PROBE) & ~suspended;
            discharge_sink <= (next_state == chg_sup_pkg::ST_DISCH);
            fault_probe <= (next_state == chg_sup_pkg::ST_FAULT_LO);
            // overvoltage moves system supply to battery
            supply_from_battery <= input_overvoltage;
            // pulled low while supply is valid
            supply_good_out <= supply_ok;
            charge_indicator_a <= (next_state == chg_sup_pkg::ST_CHARGE) & ~suspended;
            charge_indicator_b <= (next_state == chg_sup_pkg::ST_DONE);
            timer_fault <= (next_state == chg_sup_pkg::ST_FAULT_HI) ||
                           (next_state == chg_sup_pkg::ST_FAULT_LO);
        end
    end

    // open-drain: enable high while the pin is pulled low
    assign supply_good_oe = supply_good_out;
    assign charge_indicator_a_oe = charge_indicator_a;
    assign charge_indicator_b_oe = charge_indicator_b;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_supply_good;
        @(posedge core_clk) disable iff (rst)
        (clk_en && !rst) |=> supply_good_out == $past(supply_ok);
    endproperty
    a_supply_good: assert property (p_supply_good) else $error("power-good mismatch");

    property p_ind_excl;
        @(posedge core_clk) disable iff (rst)
        !(charge_indicator_a && charge_indicator_b);
    endproperty
    a_ind_excl: assert property (p_ind_excl) else $error("both indicators on");

    property p_ce_low_off;
        @(posedge core_clk) disable iff (rst)
        (clk_en && !charge_enable) |=> !converter_on && !timer_fault;
    endproperty
    a_ce_low_off: assert property (p_ce_low_off) else $error("charging while disabled");

    property p_ce_fall;
        @(posedge core_clk) disable iff (rst)
        (clk_en && ce_fall) |=> state == chg_sup_pkg::ST_IDLE;
    endproperty
    a_ce_fall: assert property (p_ce_fall) else $error("enable fall not cleared");

    property p_temp_suspend;
        @(posedge core_clk) disable iff (rst)
        (clk_en && !temp_above_cold) |=> !converter_on;
    endproperty
    a_temp_suspend: assert property (p_temp_suspend) else $error("charging while cold");

    property p_probe_drop;
        @(posedge core_clk) disable iff (rst)
        (clk_en && charge_allowed && state == chg_sup_pkg::ST_FAULT_LO && bat_above_recharge)
        |=> !fault_probe && state == chg_sup_pkg::ST_FAULT_HI;
    endproperty
    a_probe_drop: assert property (p_probe_drop) else $error("probe not dropped");

    property p_fault_clear;
        @(posedge core_clk) disable iff (rst)
        (clk_en && charge_allowed && state == chg_sup_pkg::ST_FAULT_HI && !bat_above_recharge)
        |=> discharge_sink;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");

    property p_disch_low;
        @(posedge core_clk) disable iff (rst)
        (clk_en && charge_allowed && state == chg_sup_pkg::ST_DISCH && bat_below_low)
        |=> !discharge_sink && state == chg_sup_pkg::ST_PROBE;
    endproperty
    a_disch_low: assert property (p_disch_low) else $error("sink not released");

    property p_absent;
        @(posedge core_clk) disable iff (rst)
        (clk_en && charge_allowed && state == chg_sup_pkg::ST_PROBE && bat_above_recharge)
        |=> state == chg_sup_pkg::ST_DISCH;
    endproperty
    a_absent: assert property (p_absent) else $error("absent not restarted");

    property p_start_window;
        @(posedge core_clk) disable iff (rst)
        (clk_en && state != chg_sup_pkg::ST_CHARGE && !temp_start_ok) |=> !converter_on;
    endproperty
    a_start_window: assert property (p_start_window) else $error("start out of window");

    property p_temp_resume;
        @(posedge core_clk) disable iff (rst)
        (clk_en && temp_hold && !temp_start_ok) |=> !converter_on;
    endproperty
    a_temp_resume: assert property (p_temp_resume) else $error("resumed out of window");

    property p_fault_low;
        @(posedge core_clk) disable iff (rst)
        (clk_en && charge_allowed && state == chg_sup_pkg::ST_CHARGE && safety_timeout
            && !bat_above_recharge) |=> fault_probe && timer_fault;
    endproperty
    a_fault_low: assert property (p_fault_low) else $error("fault probe missing");

    property p_detect_start;
        @(posedge core_clk) disable iff (rst)
        (clk_en && charge_allowed && state == chg_sup_pkg::ST_IDLE) |=> discharge_sink;
    endproperty
    a_detect_start: assert property (p_detect_start) else $error("detection not started");

    property p_present;
        @(posedge core_clk) disable iff (rst)
        (clk_en && charge_allowed && state == chg_sup_pkg::ST_DISCH && !bat_below_low
            && win_expired) |=> state == chg_sup_pkg::ST_CHARGE;
    endproperty
    a_present: assert property (p_present) else $error("present battery not charged");

    property p_supply_swap;
        @(posedge core_clk) disable iff (rst)
        (clk_en && !rst) |=> supply_from_battery == $past(input_overvoltage);
    endproperty
    a_supply_swap: assert property (p_supply_swap) else $error("system supply not swapped");

    c_detect: cover property (@(posedge core_clk) disable iff (rst)
        state == chg_sup_pkg::ST_DISCH ##1 state == chg_sup_pkg::ST_PROBE);
    c_present: cover property (@(posedge core_clk) disable iff (rst)
        state == chg_sup_pkg::ST_PROBE ##1 state == chg_sup_pkg::ST_CHARGE);
    c_fault_lo: cover property (@(posedge core_clk) disable iff (rst)
        state == chg_sup_pkg::ST_FAULT_LO ##1 state == chg_sup_pkg::ST_FAULT_HI);
    c_complete: cover property (@(posedge core_clk) disable iff (rst)
        state == chg_sup_pkg::ST_CHARGE ##1 state == chg_sup_pkg::ST_DONE);
    c_absent: cover property (@(posedge core_clk) disable iff (rst)
        state == chg_sup_pkg::ST_PROBE ##1 state == chg_sup_pkg::ST_DISCH);
endmodule
`default_nettype wire

// >>> rtl/chg_sup_pkg.sv
// shared constants for the charger supervisor
`default_nettype none
package chg_sup_pkg;
    // core clock rate
    localparam longint CLK_HZ = 64'd10_000_000;
    // detection windows in their own units
    localparam longint DISCH_WINDOW_MS = 64'd1000;
    localparam longint PROBE_WINDOW_MS = 64'd500;
    // windows in core clock cycles
    localparam longint DISCH_CYCLES = DISCH_WINDOW_MS * CLK_HZ / 64'd1000;
    localparam longint PROBE_CYCLES = PROBE_WINDOW_MS * CLK_HZ / 64'd1000;
    // width of the window counter
    localparam int WIN_W = 24;
    // indicator reset values (released)
    localparam logic IND_RESET = 1'b0;
    // supervisor states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DISCH,
        ST_PROBE,
        ST_CHARGE,
        ST_DONE,
        ST_FAULT_HI,
        ST_FAULT_LO
    } sup_state_t;
endpackage
`default_nettype wire

// >>> rtl/win_timer.sv
// window timer: loads a length, counts down, flags expiry
`timescale 1ns/100ps
`default_nettype none
module win_timer #(
    parameter int W = 24
) (
    input wire logic core_clk, // clock
    input wire logic rst, // async reset, high
    input wire logic ce, // clock enable
    input wire logic load, // start a new window
    input wire logic [W-1:0] length, // window length in cycles
    input wire logic run, // count while high
    output logic expired // window has run out
);
    logic [W-1:0] count;

    // countdown, expiry held until reload
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            expired <= 1'b0;
        end else if (ce) begin
            if (load) begin
                count <= length;
                expired <= 1'b0;
            end else if (run && count != '0) begin
                count <= count - 1'b1;
                expired <= (count == {{(W-1){1'b0}}, 1'b1});
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/battery_pack_model.sv
// battery pack model: holds a set level, or floats when the pack is absent
`timescale 1ns/100ps
`default_nettype none
module battery_pack_model (
    input wire logic core_clk, // clock
    input wire logic rst, // async reset, high
    input wire logic present, // pack inserted
    input wire logic [1:0] set_level, // 0 low, 1 mid, 2 above recharge
    input wire logic discharge_sink, // sink pulling the node down
    input wire logic probe_charge, // probe current into the node
    output logic bat_below_low, // node under low level
    output logic bat_above_recharge // node over recharge threshold
);
    logic [1:0] level;
    logic [1:0] ramp;
    wire logic moving = (discharge_sink && level != 2'h0) || (probe_charge && level != 2'h2);
    // an empty node swings within a few cycles, far inside either window
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            level <= 2'h2;
            ramp <= 2'h0;
        end else if (present) begin
            level <= set_level;
            ramp <= 2'h0;
        end else if (moving) begin
            ramp <= ramp + 2'h1;
            if (ramp == 2'h3) begin
                level <= discharge_sink ? 2'h0 : 2'h2;
            end
        end else begin
            ramp <= 2'h0;
        end
    end
    // level decode towards the comparators
    assign bat_below_low = (level == 2'h0);
    assign bat_above_recharge = (level == 2'h2);
endmodule
`default_nettype wire

// >>> bench/test_charger_supervisor_fsm.sv
// self-checking testbench of the charger supervisor
`timescale 1ns/100ps
`default_nettype none
module test_charger_supervisor_fsm;
    // ------------------------------------------------
    // signals and helpers
    // ------------------------------------------------
    localparam logic [8:0] CONV = 9'h100, PRB = 9'h080, SNK = 9'h040, FPR = 9'h020;
    localparam logic [8:0] SFB = 9'h010, PG = 9'h008, IA = 9'h004, IB = 9'h002, TF = 9'h001;
    logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, charge_enable = 1'b0;
    logic above_cold = 1'b1, below_hot = 1'b1, below_cut = 1'b1, uv = 1'b0, ov = 1'b0;
    logic sleep_mode = 1'b0, safety_timeout = 1'b0, charge_done = 1'b0, present = 1'b1;
    logic [1:0] set_level = 2'h1;
    logic [2:0] supply;
    wire logic low, rech, conv, prb, snk, fpr, sfb, pg, pg_oe, ia, ia_oe, ib, ib_oe, tf;
    wire logic [8:0] obs = {conv, prb, snk, fpr, sfb, pg, ia, ib, tf};
    integer seed = 96;
    int mismatches = 0, checks = 0;
    // 100 ns period
    always #50 core_clk = ~core_clk;
    battery_pack_model i_battery_pack_model (.core_clk(core_clk), .rst(rst), .present(present),
        .set_level(set_level), .discharge_sink(snk), .probe_charge(prb),
        .bat_below_low(low), .bat_above_recharge(rech));
    charger_supervisor_fsm #(.DISCH_LEN(20), .PROBE_LEN(10)) i_charger_supervisor_fsm (
        .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .charge_enable(charge_enable),
        .temp_above_cold(above_cold), .temp_below_hot_start(below_hot),
        .temp_below_hot_cutoff(below_cut), .bat_below_low(low), .bat_above_recharge(rech),
        .undervoltage_lockout(uv), .input_overvoltage(ov), .sleep_mode(sleep_mode),
        .safety_timeout(safety_timeout), .charge_done(charge_done), .converter_on(conv),
        .probe_charge(prb), .discharge_sink(snk), .fault_probe(fpr),
        .supply_from_battery(sfb), .supply_good_out(pg), .supply_good_oe(pg_oe),
        .charge_indicator_a(ia), .charge_indicator_a_oe(ia_oe), .charge_indicator_b(ib),
        .charge_indicator_b_oe(ib_oe), .timer_fault(tf));
    // power good expected only with no lockout, overvoltage or sleep
    function automatic logic pg_exp(input logic [2:0] s);
        return s == 3'h0;
    endfunction
    // bounded wait for a masked pattern, refused if it shows before lo cycles
    task automatic wait_for(input string what, input logic [8:0] mask, input logic [8:0] exp,
        input int lo, input int hi);
        int n;
        n = 0;
        #1;
        while ((obs & mask) !== exp && n < hi) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        checks += 2;
        if (n < lo || (obs & mask) !== exp) begin
            mismatches++;
            $display("BAD %s exp %h got %h after %0d", what, exp, obs & mask, n);
        end
        if ({pg_oe, ia_oe, ib_oe} !== {pg, ia, ib}) begin
            mismatches++;
            $display("BAD %s enables exp %b got %b", what, {pg, ia, ib}, {pg_oe, ia_oe, ib_oe});
        end
    endtask
    task automatic timeout_pulse;
        @(posedge core_clk);
        safety_timeout <= 1'b1;
        @(posedge core_clk);
        safety_timeout <= 1'b0;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        close_out();
    end
    // ------------------------------------------------
    // test sequence
    // ------------------------------------------------
    initial begin
        repeat (3) @(posedge core_clk);
        wait_for("reset", 9'h1FF, 9'h000, 0, 0);
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        // supply combinations walked in order, then drawn at random
        for (int i = 0; i < 16; i++) begin
            @(posedge core_clk);
            supply = (i < 8) ? 3'(i) : 3'($random(seed));
            {uv, ov, sleep_mode} <= supply;
            repeat (1 + ($unsigned($random(seed)) % 3)) @(posedge core_clk);
            wait_for("supply", PG | SFB, {4'h0, supply[1], pg_exp(supply), 3'h0}, 0, 0);
        end
        @(posedge core_clk);
        {uv, ov, sleep_mode} <= 3'h0;
        $display("test supply done");
        charge_enable <= 1'b1;
        wait_for("sink", SNK, SNK, 0, 3);
        wait_for("charge", CONV | IA | IB | SNK, CONV | IA, 17, 26);
        // suspend on hot cutoff, resume only inside the start window
        @(posedge core_clk);
        below_cut <= 1'b0;
        wait_for("suspend", CONV | IA | IB, 9'h000, 0, 3);
        below_hot <= 1'b0;
        below_cut <= 1'b1;
        repeat (2 + ($unsigned($random(seed)) % 6)) @(posedge core_clk);
        wait_for("held", CONV, 9'h000, 0, 0);
        below_hot <= 1'b1;
        wait_for("resume", CONV | IA, CONV | IA, 0, 3);
        @(posedge core_clk);
        charge_done <= 1'b1;
        @(posedge core_clk);
        charge_done <= 1'b0;
        wait_for("complete", IA | IB, IB, 0, 3);
        charge_enable <= 1'b0;
        wait_for("disable", CONV | PRB | SNK | IA | IB, 9'h000, 0, 3);
        $display("test charge done");
        // fault above recharge clears when battery drops
        @(posedge core_clk);
        charge_enable <= 1'b1;
        wait_for("recharge", CONV | IA, CONV | IA, 0, 30);
        set_level <= 2'h2;
        timeout_pulse();
        wait_for("fault hi", TF | FPR | CONV | IA, TF, 0, 3);
        @(posedge core_clk);
        set_level <= 2'h1;
        wait_for("fault clear", TF | SNK, SNK, 0, 3);
        wait_for("charge again", CONV | IA, CONV | IA, 17, 26);
        // fault below recharge keeps probe current until the battery rises
        timeout_pulse();
        wait_for("fault lo", TF | FPR | CONV, TF | FPR, 0, 3);
        repeat (3 + ($unsigned($random(seed)) % 8)) @(posedge core_clk);
        wait_for("probe held", FPR, FPR, 0, 0);
        set_level <= 2'h2;
        wait_for("probe off", TF | FPR, TF, 0, 3);
        @(posedge core_clk);
        set_level <= 2'h1;
        wait_for("redetect", TF | SNK, SNK, 0, 3);
        wait_for("charge three", CONV | IA, CONV | IA, 17, 26);
        // enable falling clears the fault, cold battery blocks a new cycle
        timeout_pulse();
        wait_for("fault", TF, TF, 0, 3);
        charge_enable <= 1'b0;
        above_cold <= 1'b0;
        wait_for("enable clears", TF | CONV, 9'h000, 0, 3);
        @(posedge core_clk);
        charge_enable <= 1'b1;
        wait_for("timers reset", SNK, SNK, 0, 3);
        repeat (30) @(posedge core_clk);
        wait_for("cold start", CONV | IA, 9'h000, 0, 0);
        above_cold <= 1'b1;
        wait_for("warm start", CONV | IA, CONV | IA, 0, 3);
        $display("test fault done");
        // pack removed: sink pulls node low, probe lifts it, detection restarts
        @(posedge core_clk);
        present <= 1'b0;
        charge_enable <= 1'b0;
        repeat (2) @(posedge core_clk);
        charge_enable <= 1'b1;
        wait_for("absent sink", SNK, SNK, 0, 3);
        wait_for("probe", PRB | SNK | IA | IB, PRB, 0, 10);
        wait_for("absent", PRB | SNK | IA | IB, SNK, 0, 10);
        @(posedge core_clk);
        ov <= 1'b1;
        wait_for("overvoltage", SFB | CONV | PG | IA, SFB, 0, 3);
        // clock enable low freezes every output while the supply recovers
        clk_en <= 1'b0;
        ov <= 1'b0;
        repeat (4) @(posedge core_clk);
        wait_for("frozen", SFB | PG | SNK, SFB, 0, 0);
        clk_en <= 1'b1;
        wait_for("thawed", SFB | PG | SNK, PG | SNK, 0, 3);
        $display("test detect done");
        close_out();
    end
endmodule
`default_nettype wire
